// >>> pkg/tzp_pkg.sv
// Shared constants and types for the counter unit and its prescaler
package tzp_pkg;

	// ------------------------------------------------------------
	// Configuration carried as one group
	// ------------------------------------------------------------
	typedef struct packed {
		logic clock_source_select;
		logic source_edge_select;
		logic prescaler_assign;
		logic [2:0] prescale_ratio;
	} tzp_cfg_s;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int COUNT_W = 8;
	localparam int PRE_W = 8;
	localparam int PHASE_W = 2;
	localparam int INHIBIT_W = 2;

	// ------------------------------------------------------------
	// Internal phase clock: four oscillator periods per instruction cycle
	// ------------------------------------------------------------
	localparam logic [PHASE_W-1:0] PHASE_ONE = 2'h0;
	localparam logic [PHASE_W-1:0] PHASE_TWO = 2'h1;
	localparam logic [PHASE_W-1:0] PHASE_THREE = 2'h2;
	localparam logic [PHASE_W-1:0] PHASE_FOUR = 2'h3;
	localparam logic [PHASE_W-1:0] PHASE_STEP = 2'h1;

	// ------------------------------------------------------------
	// Counts and values after reset
	// ------------------------------------------------------------
	localparam logic [INHIBIT_W-1:0] INHIBIT_CYCLES = 2'h2;
	localparam logic [INHIBIT_W-1:0] INHIBIT_STEP = 2'h1;
	localparam logic [INHIBIT_W-1:0] INHIBIT_NONE = 2'h0;
	localparam logic [COUNT_W-1:0] COUNT_MAX = 8'hFF;
	localparam logic [COUNT_W-1:0] COUNT_STEP = 8'h01;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
	localparam logic [PRE_W-1:0] PRE_RESET = 8'h00;
	localparam logic [PHASE_W-1:0] PHASE_RESET = 2'h0;

	// ------------------------------------------------------------
	// Timing of the external input, in oscillator periods of 25 ns
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int EXT_DELAY_MIN_TOSC = 3;
	localparam int EXT_DELAY_MAX_TOSC = 7;

endpackage

// >>> core/tzp_prescaler.sv
// Shared eight-stage ripple prescaler for the counter unit or the watchdog
`timescale 1ns/10ps

module tzp_prescaler
	import tzp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic in_pulse,
	input wire logic clear,
	input wire logic [2:0] ratio,
	output logic div_level,
	output logic wrap
);

	// ------------------------------------------------------------
	// Stage state
	// ------------------------------------------------------------
	logic [PRE_W-1:0] stage_reg;
	logic [PRE_W-1:0] stage_next;
	logic [PRE_W:0] carry;
	logic [3:0] tap;

	assign carry[0] = in_pulse;

	// Each stage toggles when every stage below it has wrapped, as in a ripple chain
	generate
		for (genvar i = 0; i < PRE_W; i++) begin : g_stage
			assign carry[i+1] = carry[i] & stage_reg[i];
			assign stage_next[i] = clear ? 1'b0 : (stage_reg[i] ^ carry[i]);
		end
	endgenerate

	// Register the stages
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stage_reg <= PRE_RESET;
		end else begin
			stage_reg <= stage_next;
		end
	end

	// Ratio 000 taps stage 0 for 1:2, each step doubles up to 1:256
	assign tap = {1'b0, ratio} + 4'h1;
	assign div_level = stage_reg[ratio]; // Square wave, half the period high
	assign wrap = carry[tap] & ~clear;

	// A clear leaves every stage at zero, so software cannot see a partial count
	a_clear_zeroes: assert property (@(posedge clk_sys) disable iff (rst)
		clear |=> stage_reg == PRE_RESET)
		else $error("prescaler not zero after clear");

endmodule

// >>> core/tzp_timer.sv
// Counter unit: 8-bit timer/counter with shared prescaler and overflow flag
`timescale 1ns/10ps

// What this block does
// - Clock select 0: timer mode, one increment per instruction cycle without prescaler.
// - After a write to the count register, increments are held off two cycles.
// - Clock select 1: counter mode, counting edges of the external count input.
// - Edge select 0 counts rising edges, 1 counts falling edges.
// - Prescaler assign 0 gives the prescaler to the timer, 1 to the watchdog.
// - Timer prescale ratios run from 1:2 to 1:256 in powers of two.
// - Software has no path to read or write the prescaler count.
// - Rolling over from FFh to 00h sets the overflow flag.
// - The overflow interrupt request is raised only while its enable is 1.
// - The timer is stopped in sleep, so its overflow never wakes the core.
// - Prescaler output or raw input is sampled on phase two and phase four.
// - The prescaler is a ripple divider giving a symmetrical output.
// - With the prescaler on the watchdog, external edge to increment takes three to seven oscillator periods.
// - One 8-bit divider serves the timer or the watchdog, never both.
// - With the prescaler on the timer, a count register write clears it.
// - With the prescaler on the watchdog, a watchdog clear clears it too.
// - The count register is 8 bits, readable and writable, overflow is the event.
module tzp_timer
	import tzp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire tzp_cfg_s cfg,
	input wire logic sleep_mode,
	input wire logic count_wr,
	input wire logic [COUNT_W-1:0] count_wr_data,
	output logic [COUNT_W-1:0] count_value,
	input wire logic flag_clear,
	input wire logic overflow_irq_enable,
	output logic overflow_flag,
	output logic overflow_irq,
	input wire logic ext_count_input,
	input wire logic watchdog_clear_instr,
	input wire logic watchdog_tick,
	output logic watchdog_out
);

	// ------------------------------------------------------------
	// Internal phase clock
	// ------------------------------------------------------------
	logic [PHASE_W-1:0] phase_reg;
	logic [PHASE_W-1:0] phase_next;
	logic cycle_end;

	// Four oscillator periods make one instruction cycle
	always_comb begin
		phase_next = phase_reg + PHASE_STEP;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			phase_reg <= PHASE_RESET;
		end else begin
			phase_reg <= phase_next;
		end
	end

	assign cycle_end = (phase_reg == PHASE_FOUR); // Last phase of the instruction cycle

	// ------------------------------------------------------------
	// External input edge conditioning
	// ------------------------------------------------------------
	logic src_level;
	logic src_prev_reg;
	logic src_prev_next;
	logic src_rise;

	// Inverting the input for falling-edge mode lets one rising detector serve both
	assign src_level = ext_count_input ^ cfg.source_edge_select;

	always_comb begin
		src_prev_next = src_level;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			src_prev_reg <= 1'b0;
		end else begin
			src_prev_reg <= src_prev_next;
		end
	end

	assign src_rise = src_level & ~src_prev_reg; // Selected edge of the pin

	// ------------------------------------------------------------
	// Shared prescaler routing
	// ------------------------------------------------------------
	logic pre_to_timer;
	logic pre_in;
	logic pre_clear;
	logic pre_level;
	logic pre_wrap;
	logic timer_src_pulse;

	// Exactly one user owns the divider at any time
	assign pre_to_timer = ~cfg.prescaler_assign;

	// Timer side feeds instruction cycles or pin edges, gated off in sleep
	assign timer_src_pulse = cfg.clock_source_select ? src_rise : cycle_end;

	// Routing of input and clear follows the owner
	assign pre_in = pre_to_timer ? (timer_src_pulse & ~sleep_mode) : watchdog_tick;
	assign pre_clear = pre_to_timer ? count_wr : watchdog_clear_instr;

	// The divider has no software-visible port, only its tap and wrap
	tzp_prescaler u_prescaler (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_pulse(pre_in),
		.clear(pre_clear),
		.ratio(cfg.prescale_ratio),
		.div_level(pre_level),
		.wrap(pre_wrap)
	);

	// ------------------------------------------------------------
	// Phase synchroniser
	// ------------------------------------------------------------
	logic sync_src;
	logic sync_a_reg;
	logic sync_a_next;
	logic sync_b_reg;
	logic sync_b_next;
	logic sync_b_prev_reg;
	logic sync_b_prev_next;
	logic sync_rise;

	// Prescaler tap when owned, otherwise the conditioned raw pin
	assign sync_src = pre_to_timer ? pre_level : src_level;

	// First stage samples on phase two, second on phase four
	always_comb begin
		sync_a_next = sync_a_reg;
		sync_b_next = sync_b_reg;
		if (phase_reg == PHASE_TWO) begin
			sync_a_next = sync_src;
		end
		if (phase_reg == PHASE_FOUR) begin
			sync_b_next = sync_a_reg;
		end
		sync_b_prev_next = sync_b_reg;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync_a_reg <= 1'b0;
			sync_b_reg <= 1'b0;
			sync_b_prev_reg <= 1'b0;
		end else begin
			sync_a_reg <= sync_a_next;
			sync_b_reg <= sync_b_next;
			sync_b_prev_reg <= sync_b_prev_next;
		end
	end

	// Only the second stage is edge-detected, the first stays free to settle
	assign sync_rise = sync_b_reg & ~sync_b_prev_reg;

	// ------------------------------------------------------------
	// Increment request and write inhibit
	// ------------------------------------------------------------
	logic direct_mode;
	logic inc_req;
	logic inc_ok;
	logic [INHIBIT_W-1:0] inhibit_reg;
	logic [INHIBIT_W-1:0] inhibit_next;

	// Timer mode with the prescaler on the watchdog counts every cycle undivided
	assign direct_mode = ~cfg.clock_source_select & cfg.prescaler_assign;

	// Sleep stops the timer, so no overflow can occur to wake the core
	assign inc_req = ~sleep_mode & (direct_mode ? cycle_end : sync_rise);

	// A write arms a hold-off of two instruction cycles; users must pre-adjust the value
	always_comb begin
		inhibit_next = inhibit_reg;
		if (count_wr) begin
			inhibit_next = INHIBIT_CYCLES;
		end else if (cycle_end && (inhibit_reg != INHIBIT_NONE)) begin
			inhibit_next = inhibit_reg - INHIBIT_STEP;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			inhibit_reg <= INHIBIT_NONE;
		end else begin
			inhibit_reg <= inhibit_next;
		end
	end

	assign inc_ok = inc_req & (inhibit_reg == INHIBIT_NONE) & ~count_wr;

	// ------------------------------------------------------------
	// Count register and overflow
	// ------------------------------------------------------------
	logic [COUNT_W-1:0] count_reg;
	logic [COUNT_W-1:0] count_next;
	logic ovf_set;
	logic flag_reg;
	logic flag_next;
	logic irq_reg;
	logic irq_next;

	// Software write has priority over an increment in the same cycle
	always_comb begin
		count_next = count_reg;
		if (count_wr) begin
			count_next = count_wr_data;
		end else if (inc_ok) begin
			count_next = count_reg + COUNT_STEP;
		end
	end

	// Rollover from the top value is the interrupt event
	assign ovf_set = inc_ok & (count_reg == COUNT_MAX);

	// Flag is sticky; hardware never clears it and a set beats a clear
	always_comb begin
		flag_next = ovf_set | (flag_reg & ~flag_clear);
		irq_next = flag_next & overflow_irq_enable; // Masked by the enable
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count_reg <= COUNT_RESET;
			flag_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			flag_reg <= flag_next;
			irq_reg <= irq_next;
		end
	end

	assign count_value = count_reg;
	assign overflow_flag = flag_reg;
	assign overflow_irq = irq_reg;

	// ------------------------------------------------------------
	// Watchdog side of the divider
	// ------------------------------------------------------------
	logic wdt_out_reg;
	logic wdt_out_next;

	// Postscaled when the watchdog owns the divider, otherwise undivided
	always_comb begin
		wdt_out_next = cfg.prescaler_assign ? pre_wrap : watchdog_tick;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wdt_out_reg <= 1'b0;
		end else begin
			wdt_out_reg <= wdt_out_next;
		end
	end

	assign watchdog_out = wdt_out_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_write_then_quiet;
		count_wr ##1 (!count_wr) [*4];
	endsequence

	sequence s_pin_edge;
		cfg.clock_source_select && cfg.prescaler_assign && !sleep_mode && src_rise;
	endsequence

	a_write_loads_count: assert property (@(posedge clk_sys) disable iff (rst)
		count_wr |=> count_value == $past(count_wr_data))
		else $error("count register did not take the written value");

	a_inhibit_after_write: assert property (@(posedge clk_sys) disable iff (rst)
		s_write_then_quiet |-> count_value == $past(count_wr_data, 4))
		else $error("count moved inside the write hold-off");

	a_timer_direct_step: assert property (@(posedge clk_sys) disable iff (rst)
		(direct_mode && cycle_end && !sleep_mode && !count_wr && inhibit_reg == INHIBIT_NONE)
		|=> count_value == COUNT_W'($past(count_value) + COUNT_STEP))
		else $error("timer did not step once per instruction cycle");

	a_rollover_flag: assert property (@(posedge clk_sys) disable iff (rst)
		(inc_ok && count_value == COUNT_MAX) |=> (overflow_flag && count_value == COUNT_RESET))
		else $error("rollover did not set the overflow flag");

	a_set_beats_clear: assert property (@(posedge clk_sys) disable iff (rst)
		(ovf_set && flag_clear) |=> overflow_flag)
		else $error("overflow lost against a same-cycle clear");

	a_flag_sticky: assert property (@(posedge clk_sys) disable iff (rst)
		(overflow_flag && !flag_clear) |=> overflow_flag)
		else $error("overflow flag dropped without software clear");

	a_irq_mask: assert property (@(posedge clk_sys) disable iff (rst)
		##1 (overflow_irq == (overflow_flag && $past(overflow_irq_enable))))
		else $error("interrupt request does not follow flag and enable");

	a_sleep_freeze: assert property (@(posedge clk_sys) disable iff (rst)
		(sleep_mode && !count_wr) |=> $stable(count_value))
		else $error("count moved during sleep");

	a_pin_edge_delay: assert property (@(posedge clk_sys) disable iff (rst)
		s_pin_edge ##1 (src_level && cfg.clock_source_select && cfg.prescaler_assign) [*5]
		|=> sync_rise || $past(sync_rise, 1) || $past(sync_rise, 2) || $past(sync_rise, 3))
		else $error("pin edge not seen within seven oscillator periods");

	a_wdt_undivided: assert property (@(posedge clk_sys) disable iff (rst)
		!cfg.prescaler_assign |=> watchdog_out == $past(watchdog_tick))
		else $error("watchdog tick divided while the timer owns the prescaler");

	a_timer_undivided_wdt: assert property (@(posedge clk_sys) disable iff (rst)
		cfg.prescaler_assign |-> pre_in == watchdog_tick)
		else $error("timer source reached the divider while the watchdog owns it");

	// A cleared divider shows a low tap, so a stale half count cannot leak into the count
	a_write_clears_pre: assert property (@(posedge clk_sys) disable iff (rst)
		(count_wr && pre_to_timer) |=> !pre_level)
		else $error("timer write left the prescaler tap set");

	a_wdt_clear_pre: assert property (@(posedge clk_sys) disable iff (rst)
		(watchdog_clear_instr && cfg.prescaler_assign) |=> !pre_level)
		else $error("watchdog clear left the prescaler tap set");

	// Each synchroniser stage may only move on its own phase
	a_sync_a_phase: assert property (@(posedge clk_sys) disable iff (rst)
		(phase_reg != PHASE_TWO) |=> $stable(sync_a_reg))
		else $error("first sync stage moved outside phase two");

	a_sync_b_phase: assert property (@(posedge clk_sys) disable iff (rst)
		(phase_reg != PHASE_FOUR) |=> $stable(sync_b_reg))
		else $error("second sync stage moved outside phase four");

	a_count_idle: assert property (@(posedge clk_sys) disable iff (rst)
		(!count_wr && !inc_ok) |=> $stable(count_value))
		else $error("count moved with neither write nor increment");

endmodule

// >>> testbench/tzp_pulse_src.sv
// Behavioural external count source that drives the count pin
`timescale 1ns/10ps

module tzp_pulse_src (
	input wire logic clk_sys,
	input wire logic go,
	input wire logic [7:0] n_pulse,
	input wire logic [3:0] hi_cyc,
	input wire logic [3:0] lo_cyc,
	output logic pin,
	output logic busy
);
	// Pin idles low between bursts
	initial begin
		pin = 1'b0;
		busy = 1'b0;
	end

	// A burst of whole-cycle pulses; the bench picks widths that the pin may carry
	always begin
		@(posedge clk_sys);
		if (go === 1'b1) begin
			busy <= 1'b1;
			for (int i = 0; i < n_pulse; i++) begin
				pin <= 1'b1;
				repeat (hi_cyc) @(posedge clk_sys);
				pin <= 1'b0;
				repeat (lo_cyc) @(posedge clk_sys);
			end
			busy <= 1'b0;
		end
	end
endmodule

// >>> testbench/tb_tzp_timer.sv
// Self-checking bench for the counter unit with its shared prescaler
`timescale 1ns/10ps

module tb_tzp_timer
	import tzp_pkg::*;
;
	// ----------------------------------------
	// Stimulus, observation and bookkeeping
	// ----------------------------------------
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	tzp_cfg_s cfg = '{1'b0, 1'b0, 1'b1, 3'h0};
	logic sleep_mode = 1'b0, count_wr = 1'b0, flag_clear = 1'b0, en = 1'b1;
	logic wd_clr = 1'b0, wd_tick = 1'b0, go = 1'b0, trk = 1'b0, trk_on = 1'b0, pin_q = 1'b0;
	logic [7:0] wr_data = 8'h00, n_pulse = 8'h00, cnt_q = 8'h00, d, e;
	logic [3:0] hi_cyc = 4'h6, lo_cyc = 4'h6;
	logic [7:0] count_value;
	logic overflow_flag, overflow_irq, watchdog_out, pin, busy;
	int miscompares = 0, checks = 0, wd_n = 0, dly = 0, m, n, b;
	logic [31:0] seed = 32'h0000_0051;

	always #12.5 clk_sys = ~clk_sys;

	tzp_timer i_tzp_timer (.clk_sys(clk_sys), .rst(rst), .cfg(cfg), .sleep_mode(sleep_mode),
		.count_wr(count_wr), .count_wr_data(wr_data), .count_value(count_value),
		.flag_clear(flag_clear), .overflow_irq_enable(en), .overflow_flag(overflow_flag),
		.overflow_irq(overflow_irq), .ext_count_input(pin), .watchdog_clear_instr(wd_clr),
		.watchdog_tick(wd_tick), .watchdog_out(watchdog_out));

	tzp_pulse_src i_tzp_pulse_src (.clk_sys(clk_sys), .go(go), .n_pulse(n_pulse),
		.hi_cyc(hi_cyc), .lo_cyc(lo_cyc), .pin(pin), .busy(busy));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic fail(input string msg);
		miscompares++;
		$display("Error at %0t: %s", $time, msg);
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) fail($sformatf("%s got %h want %h", what, got, exp));
	endtask

	task automatic chk1(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp) fail($sformatf("%s got %b want %b", what, got, exp));
	endtask

	// Prescaled counts land within one step, the sync delay shifts the first edge
	task automatic chk_near(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp && got !== exp + 8'h01 && got !== exp - 8'h01)
			fail($sformatf("%s got %h near %h", what, got, exp));
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] v);
		@(posedge clk_sys);
		count_wr <= 1'b1;
		wr_data <= v;
		@(posedge clk_sys);
		count_wr <= 1'b0;
	endtask

	task automatic tk(input int k);
		repeat (k) begin
			@(posedge clk_sys);
			wd_tick <= 1'b1;
			@(posedge clk_sys);
			wd_tick <= 1'b0;
		end
	endtask

	// Burst from the source; the wait is bounded so a stuck source ends the run
	task automatic send(input int k, input logic [3:0] h, input logic [3:0] l);
		int i;
		@(posedge clk_sys);
		go <= 1'b1;
		n_pulse <= k[7:0];
		hi_cyc <= h;
		lo_cyc <= l;
		@(posedge clk_sys);
		go <= 1'b0;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (busy === 1'b1 && i < 600);
		if (i >= 600) begin
			fail("source never finished");
			wrap_up();
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Watchdog pulses counted, and selected pin edge timed to the next count change
	always @(posedge clk_sys) begin
		pin_q <= pin;
		cnt_q <= count_value;
		if (watchdog_out === 1'b1) wd_n <= wd_n + 1;
		if (trk) dly <= dly + 1;
		if (trk && count_value !== cnt_q) begin
			trk <= 1'b0;
			checks++;
			if (dly < 3 || dly > 7) fail("edge to increment delay");
		end else if (trk_on && pin !== pin_q && pin === ~cfg.source_edge_select) begin
			trk <= 1'b1;
			dly <= 1;
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		@(negedge clk_sys);
		chk8(count_value, 8'h00, "reset count");
		chk1(overflow_flag, 1'b0, "reset flag");
		chk1(overflow_irq, 1'b0, "reset irq");
		cyc(6);
		rst <= 1'b0;
		wr(8'hFD);
		cyc(16);
		@(negedge clk_sys);
		chk8(count_value, 8'hFF, "hold-off");
		cyc(4);
		@(negedge clk_sys);
		chk8(count_value, 8'h00, "rollover");
		chk1(overflow_flag, 1'b1, "flag set");
		chk1(overflow_irq, 1'b1, "irq raised");
		@(posedge clk_sys);
		flag_clear <= 1'b1;
		@(posedge clk_sys);
		flag_clear <= 1'b0;
		@(negedge clk_sys);
		chk1(overflow_flag, 1'b0, "flag cleared");
		chk1(overflow_irq, 1'b0, "irq dropped");
		@(posedge clk_sys);
		en <= 1'b0;
		wr(8'hFF);
		cyc(8);
		// Clear lands on the rollover edge: the set must win
		flag_clear <= 1'b1;
		@(posedge clk_sys);
		flag_clear <= 1'b0;
		cyc(7);
		@(negedge clk_sys);
		chk8(count_value, 8'h01, "write then roll");
		chk1(overflow_flag, 1'b1, "masked flag");
		chk1(overflow_irq, 1'b0, "masked irq");
		for (b = 0; b < 3; b++) begin
			d = 8'(rnd());
			m = 1 + int'(rnd() % 32'd60);
			wr(d);
			cyc(16 + 4 * m);
			e = 8'(d + 8'h02 + m);
			@(negedge clk_sys);
			chk8(count_value, e, "timer run");
		end
		@(posedge clk_sys);
		sleep_mode <= 1'b1;
		cyc(40);
		@(negedge clk_sys);
		chk_near(count_value, e + 8'h01, "sleep hold");
		@(posedge clk_sys);
		sleep_mode <= 1'b0;
		$display("test timer direct done");
		for (b = 0; b < 8; b++) begin
			@(posedge clk_sys);
			cfg <= '{1'b0, 1'b0, 1'b0, 3'(b)};
			wr(8'h00);
			cyc(48 << b);
			@(negedge clk_sys);
			chk_near(count_value, 8'h06, "prescaled timer");
		end
		$display("test timer prescaled done");
		trk_on <= 1'b1;
		for (b = 0; b < 2; b++) begin
			@(posedge clk_sys);
			cfg <= '{1'b1, 1'(b), 1'b1, 3'h0};
			cyc(12);
			wr(8'h00);
			cyc(8);
			n = 3 + int'(rnd() % 32'd8);
			send(n, 4'h6, 4'h6);
			cyc(12);
			@(negedge clk_sys);
			chk8(count_value, 8'(n), "edge count");
		end
		@(posedge clk_sys);
		trk_on <= 1'b0;
		cfg <= '{1'b1, 1'b0, 1'b0, 3'h0};
		cyc(12);
		wr(8'h00);
		cyc(8);
		send(2 * n, 4'h3, 4'h3);
		cyc(12);
		@(negedge clk_sys);
		chk8(count_value, 8'(n), "prescaled edges");
		$display("test counter done");
		@(posedge clk_sys);
		wd_clr <= 1'b1;
		@(posedge clk_sys);
		wd_clr <= 1'b0;
		cfg <= '{1'b0, 1'b0, 1'b1, 3'h1};
		@(posedge clk_sys);
		wd_clr <= 1'b1;
		@(posedge clk_sys);
		wd_clr <= 1'b0;
		b = wd_n;
		tk(16);
		cyc(4);
		chk8(8'(wd_n - b), 8'h04, "postscaled watchdog");
		@(posedge clk_sys);
		cfg <= '{1'b0, 1'b0, 1'b0, 3'h1};
		b = wd_n;
		tk(5);
		cyc(4);
		chk8(8'(wd_n - b), 8'h05, "undivided watchdog");
		$display("test watchdog done");
		wrap_up();
	end
endmodule
